// ===== rtl/ua1_pkg.sv
// Constants for the ten-bit-frame asynchronous serial port: map, fields, resets.
// Assumes a single 10 MHz clock and an Avalon-MM master that honours waitrequest.
package ua1_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int ADDR_W = 5;
	localparam logic [4:0] OFF_DATA = 5'h00;
	localparam logic [4:0] OFF_CTRL = 5'h04;
	localparam logic [4:0] OFF_BAUD = 5'h08;
	localparam logic [4:0] OFF_STAT = 5'h0C;
	localparam logic [4:0] OFF_MASK = 5'h10;

	// ----------------------------------------------------------------
	// Fields
	// ----------------------------------------------------------------
	localparam int CTRL_MPCE = 0;
	localparam int STAT_TXD = 0;
	localparam int STAT_RXD = 1;
	localparam int STAT_RB9 = 2;
	localparam int EVT_W = 2;

	// ----------------------------------------------------------------
	// Frame and timing
	// ----------------------------------------------------------------
	localparam int BYTE_W = 8;
	localparam int SHIFT_W = 9;
	localparam int OVS_W = 4;
	localparam logic [3:0] OVS_LAST = 4'hF;
	localparam logic [3:0] SMP_A = 4'h7;
	localparam logic [3:0] SMP_B = 4'h8;
	localparam logic [3:0] SMP_C = 4'h9;
	localparam logic [7:0] TX_MARK_TAIL = 8'h01;
	localparam logic [8:0] RX_FILL = 9'h1FF;
	localparam logic [3:0] TX_DONE_ROLL = 4'h9;
	localparam int BAUD_W = 16;
	localparam logic [15:0] BAUD_RST = 16'h0040;

	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_START = 2'b01,
		TX_DATA = 2'b11
	} ua1_tx_e;

	typedef enum logic {
		RX_IDLE = 1'b0,
		RX_RUN = 1'b1
	} ua1_rx_e;

endpackage

// ===== rtl/ua1_serial.sv
// Ten-bit-frame asynchronous serial port with Avalon-MM register slave.
// Assumes rxd is asynchronous to mclk; all other inputs are on mclk.
`timescale 1ns/100ps
`default_nettype none
module ua1_serial #(
	parameter logic [15:0] BAUD_DEFAULT = ua1_pkg::BAUD_RST
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic rxd,
	output logic txd,
	output logic irq
);

	// ----------------------------------------------------------------
	// Bus slave
	// ----------------------------------------------------------------
	// One wait cycle: read data are registered while waitrequest is high
	logic [7:0] rx_buf_q;
	logic mpce_q;
	logic [15:0] baud_q;
	logic [1:0] stat_q;
	logic rb9_q;
	logic [1:0] mask_q;
	logic [31:0] rdata_d;

	wire req = avs_read | avs_write;
	wire acc = req & ~avs_waitrequest;
	wire wr = acc & avs_write;
	wire sel_data = (avs_address == ua1_pkg::OFF_DATA);
	wire sel_ctrl = (avs_address == ua1_pkg::OFF_CTRL);
	wire sel_baud = (avs_address == ua1_pkg::OFF_BAUD);
	wire sel_stat = (avs_address == ua1_pkg::OFF_STAT);
	wire sel_mask = (avs_address == ua1_pkg::OFF_MASK);
	wire be0 = avs_byteenable[0];
	wire be1 = avs_byteenable[1];
	wire wr_data = wr & sel_data & be0;
	wire [1:0] stat_clr = (wr & sel_stat & be0) ? avs_writedata[1:0] : 2'b00;

	assign rdata_d = sel_data ? {24'h00_0000, rx_buf_q} :
		sel_ctrl ? {31'h0000_0000, mpce_q} :
		sel_baud ? {16'h0000, baud_q} :
		sel_stat ? {29'h0000_0000, rb9_q, stat_q} :
		sel_mask ? {30'h0000_0000, mask_q} : 32'h0000_0000;

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h0000_0000;
		end
		else
		begin
			avs_waitrequest <= ~(req & avs_waitrequest);
			avs_readdata <= rdata_d;
		end
	end

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			mpce_q <= 1'b0;
			baud_q <= BAUD_DEFAULT;
			mask_q <= 2'b00;
		end
		else
		begin
			if (wr & sel_ctrl & be0)
				mpce_q <= avs_writedata[ua1_pkg::CTRL_MPCE];
			if (wr & sel_baud & be0)
				baud_q[7:0] <= avs_writedata[7:0];
			if (wr & sel_baud & be1)
				baud_q[15:8] <= avs_writedata[15:8];
			if (wr & sel_mask & be0)
				mask_q <= avs_writedata[1:0];
		end
	end

	// ----------------------------------------------------------------
	// Oversampling tick
	// ----------------------------------------------------------------
	logic tick;

	ua1_tick_div #(
		.W(ua1_pkg::BAUD_W)
	) u_div (
		.mclk(mclk),
		.rst_b(rst_b),
		.divisor(baud_q),
		.tick(tick)
	);

	// ----------------------------------------------------------------
	// Transmitter
	// ----------------------------------------------------------------
	ua1_pkg::ua1_tx_e tx_st_q;
	ua1_pkg::ua1_tx_e tx_st_d;
	logic [3:0] tx_div_q;
	logic [8:0] tx_sh_q;
	logic [8:0] tx_sh_d;
	logic tx_req_q;
	logic tx_req_d;
	logic tx_set;
	logic txd_d;

	// Bit edges follow the free-running counter, never the buffer write
	wire tx_roll = tick & (tx_div_q == ua1_pkg::OVS_LAST);
	// Marker just behind the output, whatever the last data bit is
	wire tx_last = (tx_st_q == ua1_pkg::TX_DATA) & (tx_sh_q[8:1] == ua1_pkg::TX_MARK_TAIL);

	always_comb
	begin
		tx_st_d = tx_st_q;
		tx_sh_d = tx_sh_q;
		tx_req_d = tx_req_q;
		tx_set = 1'b0;
		if (tx_roll)
		begin
			unique case (tx_st_q)
				ua1_pkg::TX_IDLE:
					if (tx_req_q)
					begin
						tx_st_d = ua1_pkg::TX_START;
						tx_req_d = 1'b0;
					end
				ua1_pkg::TX_START:
					tx_st_d = ua1_pkg::TX_DATA;
				ua1_pkg::TX_DATA:
				begin
					tx_sh_d = {1'b0, tx_sh_q[8:1]};
					if (tx_last)
					begin
						tx_st_d = ua1_pkg::TX_IDLE;
						tx_set = 1'b1;
					end
				end
				default:
					tx_st_d = ua1_pkg::TX_IDLE;
			endcase
		end
		// A new write reloads the shifter; a frame under way is overrun by it
		if (wr_data)
		begin
			tx_sh_d = {1'b1, avs_writedata[7:0]};
			tx_req_d = 1'b1;
		end
	end

	// Start bit low, data from the shifter output, mark otherwise
	assign txd_d = (tx_st_q == ua1_pkg::TX_START) ? 1'b0 :
		(tx_st_q == ua1_pkg::TX_DATA) ? tx_sh_q[0] : 1'b1;

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			tx_st_q <= ua1_pkg::TX_IDLE;
			tx_div_q <= 4'h0;
			tx_sh_q <= 9'h000;
			tx_req_q <= 1'b0;
			txd <= 1'b1;
		end
		else
		begin
			tx_st_q <= tx_st_d;
			tx_div_q <= tick ? tx_div_q + 4'h1 : tx_div_q;
			tx_sh_q <= tx_sh_d;
			tx_req_q <= tx_req_d;
			txd <= txd_d;
		end
	end

	// ----------------------------------------------------------------
	// Receiver
	// ----------------------------------------------------------------
	ua1_pkg::ua1_rx_e rx_st_q;
	logic rxd_m_q;
	logic rxd_s_q;
	logic rx_last_q;
	logic [3:0] rx_div_q;
	logic [8:0] rx_sh_q;
	logic smp_a_q;
	logic smp_b_q;

	// The edge is judged at tick rate so it matches the bit sampling grid
	wire rx_fall = tick & (rx_st_q == ua1_pkg::RX_IDLE) & rx_last_q & ~rxd_s_q;
	wire rx_dec = tick & (rx_st_q == ua1_pkg::RX_RUN) & (rx_div_q == ua1_pkg::SMP_C);
	wire bit_v = (smp_a_q & smp_b_q) | (smp_a_q & rxd_s_q) | (smp_b_q & rxd_s_q);
	wire rx_first = (rx_sh_q == ua1_pkg::RX_FILL);
	wire rx_reject = rx_dec & rx_first & bit_v;
	wire rx_final = rx_dec & ~rx_sh_q[8];
	wire rx_ok = ~stat_q[ua1_pkg::STAT_RXD] & (~mpce_q | bit_v);
	wire rx_load = rx_final & rx_ok;
	// First bit in ends highest, so the byte is mirrored on its way to the buffer
	logic [ua1_pkg::BYTE_W-1:0] rx_byte;
	for (genvar i = 0; i < ua1_pkg::BYTE_W; i++)
	begin : g_mirror
		assign rx_byte[i] = rx_sh_q[ua1_pkg::BYTE_W - 1 - i];
	end

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rxd_m_q <= 1'b1;
			rxd_s_q <= 1'b1;
			rx_last_q <= 1'b1;
		end
		else
		begin
			rxd_m_q <= rxd;
			rxd_s_q <= rxd_m_q;
			if (tick)
				rx_last_q <= rxd_s_q;
		end
	end

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rx_st_q <= ua1_pkg::RX_IDLE;
			rx_div_q <= 4'h0;
			rx_sh_q <= ua1_pkg::RX_FILL;
			smp_a_q <= 1'b1;
			smp_b_q <= 1'b1;
		end
		else if (rx_fall)
		begin
			rx_st_q <= ua1_pkg::RX_RUN;
			rx_div_q <= 4'h0;
			rx_sh_q <= ua1_pkg::RX_FILL;
		end
		else if (tick & (rx_st_q == ua1_pkg::RX_RUN))
		begin
			rx_div_q <= rx_div_q + 4'h1;
			if (rx_div_q == ua1_pkg::SMP_A)
				smp_a_q <= rxd_s_q;
			if (rx_div_q == ua1_pkg::SMP_B)
				smp_b_q <= rxd_s_q;
			if (rx_reject | rx_final)
				rx_st_q <= ua1_pkg::RX_IDLE;
			else if (rx_dec)
				rx_sh_q <= {rx_sh_q[7:0], bit_v};
		end
	end

	// ----------------------------------------------------------------
	// Buffer, flags and interrupt
	// ----------------------------------------------------------------
	wire [1:0] evt = {rx_load, tx_set};
	// Hardware set beats a same-cycle software clear
	wire [1:0] stat_d = (stat_q & ~stat_clr) | evt;

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			stat_q <= 2'b00;
			rb9_q <= 1'b0;
			rx_buf_q <= 8'h00;
			irq <= 1'b0;
		end
		else
		begin
			stat_q <= stat_d;
			irq <= |(stat_d & mask_q);
			if (rx_load)
			begin
				rb9_q <= bit_v;
				rx_buf_q <= rx_byte;
			end
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	logic [3:0] roll_cnt_q;

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			roll_cnt_q <= 4'hF;
		else if (wr_data)
			roll_cnt_q <= 4'h0;
		else if (tx_roll & (roll_cnt_q != 4'hF))
			roll_cnt_q <= roll_cnt_q + 4'h1;
	end

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_b);

	sequence s_start_bit;
		(tx_st_q == ua1_pkg::TX_START) ##1 !txd;
	endsequence

	property p_tx_load;
		wr_data |=> tx_req_q && tx_sh_q[8] && (tx_sh_q[7:0] == $past(avs_writedata[7:0]));
	endproperty
	a_tx_load: assert property (p_tx_load) else $error("buffer write did not arm tx");

	property p_tx_go;
		tx_roll && tx_req_q && (tx_st_q == ua1_pkg::TX_IDLE) && !wr_data
			|=> s_start_bit;
	endproperty
	a_tx_go: assert property (p_tx_go) else $error("tx did not start at rollover");

	property p_tx_hold;
		(tx_st_q == ua1_pkg::TX_START) && !tx_roll |=> (tx_st_q == ua1_pkg::TX_START);
	endproperty
	a_tx_hold: assert property (p_tx_hold) else $error("start bit left early");

	property p_tx_idle;
		(tx_st_q == ua1_pkg::TX_IDLE) |=> txd;
	endproperty
	a_tx_idle: assert property (p_tx_idle) else $error("tx line not high at idle");

	property p_tx_end;
		tx_roll && tx_last |=> (tx_st_q == ua1_pkg::TX_IDLE) && stat_q[ua1_pkg::STAT_TXD]
			##1 txd;
	endproperty
	a_tx_end: assert property (p_tx_end) else $error("tx end sequence wrong");

	property p_tx_ten;
		tx_set && !wr_data |-> (roll_cnt_q == ua1_pkg::TX_DONE_ROLL);
	endproperty
	a_tx_ten: assert property (p_tx_ten) else $error("tx done not at tenth rollover");

	property p_rx_arm;
		rx_fall |=> (rx_div_q == 4'h0) && (rx_sh_q == ua1_pkg::RX_FILL)
			&& (rx_st_q == ua1_pkg::RX_RUN);
	endproperty
	a_rx_arm: assert property (p_rx_arm) else $error("rx not armed on edge");

	property p_rx_reject;
		rx_reject |=> (rx_st_q == ua1_pkg::RX_IDLE) && !stat_q[ua1_pkg::STAT_RXD]
			|| $past(stat_q[ua1_pkg::STAT_RXD]);
	endproperty
	a_rx_reject: assert property (p_rx_reject) else $error("false start kept");

	property p_rx_accept;
		rx_load |=> stat_q[ua1_pkg::STAT_RXD] && (rx_buf_q == $past(rx_byte))
			&& (rb9_q == $past(bit_v));
	endproperty
	a_rx_accept: assert property (p_rx_accept) else $error("frame not delivered");

	property p_rx_drop;
		rx_final && !rx_ok |=> $stable(rx_buf_q) && $stable(rb9_q);
	endproperty
	a_rx_drop: assert property (p_rx_drop) else $error("refused frame left a trace");

	property p_rx_rearm;
		rx_final |=> (rx_st_q == ua1_pkg::RX_IDLE);
	endproperty
	a_rx_rearm: assert property (p_rx_rearm) else $error("rx not rearmed");

endmodule
`default_nettype wire

// ===== rtl/ua1_tick_div.sv
// Sixteen-times-baud tick generator.
// Assumes divisor changes are rare; a change applies at once, to the count already under way.
`timescale 1ns/100ps
`default_nettype none
module ua1_tick_div #(
	parameter int W = 16
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic [W-1:0] divisor,
	output logic tick
);

	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;
	wire wrap = (cnt_q >= divisor);

	assign cnt_d = wrap ? '0 : cnt_q + W'(1);

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cnt_q <= '0;
			tick <= 1'b0;
		end
		else
		begin
			cnt_q <= cnt_d;
			tick <= wrap;
		end
	end

endmodule
`default_nettype wire

// ===== verif/ua1_remote.sv
// Far-end serial transceiver model: sends frames on rxd, collects frames from txd.
// Assumes the port runs at 16 mclk per bit (BAUD register 0).
`timescale 1ns/100ps
`default_nettype none
module ua1_remote (
	input wire logic mclk,
	input wire logic txd,
	output logic rxd
);
	localparam int BT = 16;
	logic [7:0] got_q;
	logic st;
	int frames;
	initial
	begin
		rxd = 1'b1;
		frames = 0;
	end
	// Start low, LSB first, stop, then idle high; gl flips one sample per bit
	task automatic send(input logic [7:0] b, input logic stp, input logic gl);
		logic [9:0] f;
		f = {stp, b, 1'b0};
		for (int i = 0; i < 10; i++)
			for (int c = 0; c < BT; c++)
			begin
				@(posedge mclk);
				rxd <= f[i] ^ (gl && c == 8);
			end
		@(posedge mclk);
		rxd <= 1'b1;
	endtask
	// Too short to win the majority vote
	task automatic pulse(input int n);
		@(posedge mclk);
		rxd <= 1'b0;
		repeat (n) @(posedge mclk);
		rxd <= 1'b1;
	endtask
	// Mid-bit sampling; a frame counts only with low start and high stop
	always
	begin
		@(negedge txd);
		repeat (BT / 2) @(posedge mclk);
		st = txd;
		for (int i = 0; i < 8; i++)
		begin
			repeat (BT) @(posedge mclk);
			got_q[i] = txd;
		end
		repeat (BT) @(posedge mclk);
		if (st === 1'b0 && txd === 1'b1)
			frames++;
	end
endmodule
`default_nettype wire

// ===== verif/ua1_serial_test.sv
// Self-checking bench for the serial port: register bus tasks plus far-end model.
// Assumes BAUD set to 0 before traffic; each access ends on waitrequest low.
`timescale 1ns/100ps
`default_nettype none
module ua1_serial_test;
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	logic [4:0] avs_address = 5'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [3:0] avs_byteenable = 4'hF;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic rxd;
	logic txd;
	logic irq;
	logic [31:0] q;
	int fail_count = 0;
	int comparisons = 0;
	int f0;
	int el;
	realtime t0;
	always #50 mclk = ~mclk;
	ua1_serial uut (.mclk(mclk), .rst_b(rst_b), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .rxd(rxd), .txd(txd), .irq(irq));
	ua1_remote remote (.mclk(mclk), .txd(txd), .rxd(rxd));
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic report_and_stop();
		if (fail_count == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic tmo();
		fail_count++;
		$display("[ERR] %0t wait ran out", $time);
		report_and_stop();
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Request held until waitrequest low is seen at an edge; read just after the
	// edge, flop outputs still show their pre-edge values, so no race
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
		input logic [3:0] be);
		int n;
		n = 0;
		@(posedge mclk);
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= be;
		avs_read <= !w;
		avs_write <= w;
		do
		begin
			@(posedge mclk);
			n++;
		end
		while (avs_waitrequest !== 1'b0 && n < 100);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (n >= 100)
			tmo();
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 4'hF);
	endtask
	task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0000_0000, 4'hF);
		check(q, exp);
	endtask
	task automatic wait_stat(input int b);
		int n;
		n = 0;
		do
		begin
			bus(1'b0, ua1_pkg::OFF_STAT, 32'h0000_0000, 4'hF);
			n++;
		end
		while (q[b] !== 1'b1 && n < 200);
		if (n >= 200)
			tmo();
	endtask
	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	initial
	begin
		repeat (20) @(posedge mclk);
		rst_b <= 1'b1;
		rd_chk(ua1_pkg::OFF_CTRL, 32'h0000_0000);
		rd_chk(ua1_pkg::OFF_BAUD, 32'h0000_0040);
		rd_chk(ua1_pkg::OFF_STAT, 32'h0000_0000);
		rd_chk(ua1_pkg::OFF_MASK, 32'h0000_0000);
		rd_chk(5'h14, 32'h0000_0000);
		// Only byte lane 0 may change
		bus(1'b1, ua1_pkg::OFF_BAUD, 32'h0000_1234, 4'h1);
		rd_chk(ua1_pkg::OFF_BAUD, 32'h0000_0034);
		wr(ua1_pkg::OFF_BAUD, 32'h0000_0000);
		check(txd, 1'b1);
		wr(ua1_pkg::OFF_DATA, 32'h0000_00A5);
		t0 = $realtime;
		f0 = remote.frames;
		wait_stat(ua1_pkg::STAT_TXD);
		el = int'(($realtime - t0) / 100.0);
		check(el >= 145 && el <= 170, 1'b1);
		check(irq, 1'b0);
		wr(ua1_pkg::OFF_MASK, 32'h0000_0003);
		repeat (2) @(negedge mclk);
		check(irq, 1'b1);
		wr(ua1_pkg::OFF_STAT, 32'h0000_0001);
		repeat (2) @(negedge mclk);
		check(irq, 1'b0);
		repeat (40) @(posedge mclk);
		check(remote.frames, f0 + 1);
		check(remote.got_q, 8'hA5);
		check(txd, 1'b1);
		remote.send(8'h35, 1'b1, 1'b0);
		wait_stat(ua1_pkg::STAT_RXD);
		check(q, 32'h0000_0006);
		rd_chk(ua1_pkg::OFF_DATA, 32'h0000_0035);
		check(irq, 1'b1);
		// Flag still set: this frame must be lost
		remote.send(8'h55, 1'b1, 1'b0);
		repeat (20) @(posedge mclk);
		rd_chk(ua1_pkg::OFF_DATA, 32'h0000_0035);
		wr(ua1_pkg::OFF_STAT, 32'h0000_0002);
		rd_chk(ua1_pkg::OFF_STAT, 32'h0000_0004);
		check(irq, 1'b0);
		remote.pulse(4);
		repeat (40) @(posedge mclk);
		rd_chk(ua1_pkg::OFF_STAT, 32'h0000_0004);
		remote.send(8'h81, 1'b0, 1'b1);
		wait_stat(ua1_pkg::STAT_RXD);
		check(q, 32'h0000_0002);
		rd_chk(ua1_pkg::OFF_DATA, 32'h0000_0081);
		wr(ua1_pkg::OFF_STAT, 32'h0000_0002);
		wr(ua1_pkg::OFF_CTRL, 32'h0000_0001);
		rd_chk(ua1_pkg::OFF_CTRL, 32'h0000_0001);
		remote.send(8'h66, 1'b0, 1'b0);
		repeat (20) @(posedge mclk);
		rd_chk(ua1_pkg::OFF_STAT, 32'h0000_0000);
		remote.send(8'h99, 1'b1, 1'b0);
		wait_stat(ua1_pkg::STAT_RXD);
		check(q, 32'h0000_0006);
		rd_chk(ua1_pkg::OFF_DATA, 32'h0000_0099);
		// Last data bit low: the end marker must still be found
		f0 = remote.frames;
		wr(ua1_pkg::OFF_DATA, 32'h0000_005A);
		wait_stat(ua1_pkg::STAT_TXD);
		repeat (40) @(posedge mclk);
		check(remote.frames, f0 + 1);
		check(remote.got_q, 8'h5A);
		check(txd, 1'b1);
		report_and_stop();
	end
endmodule
`default_nettype wire
